//--- nvmcfg_asserts.sv
module nvmcfg_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire nvmcfg_pkg::nvmcfg_req_type req,
  input wire logic sleep_mode,
  input wire logic [7:0] rd_data_q,
  input wire logic rd_valid_q,
  input wire nvmcfg_pkg::nvmcfg_cfg_out_type cfg_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  read_answer_a: assert property (req.rd |=> rd_valid_q)
    else $error("read not answered");
  read_pulse_a: assert property (!req.rd |=> !rd_valid_q)
    else $error("read valid without request");
  range_bad_a: assert property (cfg_q.range_bad
    |-> !cfg_q.full_scale_mg) else $error("bad range code with full scale");
  // Outputs sit at zero until the internal reset copy lets go
  range_scale_a: assert property ($past(rst_n, 4) && !cfg_q.range_bad
    |-> cfg_q.full_scale_mg inside {1000, 1500, 2000, 3000, 4000, 8000, 16000})
    else $error("full scale off table");
  high_pass_a: assert property (
    cfg_q.kind == nvmcfg_pkg::NVMCFG_HIGHPASS |-> cfg_q.bw_hz == 1)
    else $error("high pass width wrong");
  band_pass_a: assert property (
    cfg_q.kind == nvmcfg_pkg::NVMCFG_BANDPASS |-> cfg_q.bw_hz == 300)
    else $error("band pass width wrong");
  low_pass_a: assert property ($past(rst_n, 4) && cfg_q.kind == 0
    |-> cfg_q.bw_hz inside {10, 20, 40, 75, 150, 300, 600, 1200})
    else $error("low pass width off table");
  settle_drop_a: assert property ($past(rst_n, 4)
    && $changed(cfg_q.full_scale_mg) |-> ##[0:1] !cfg_q.data_valid)
    else $error("data valid kept over range change");
  wake_wide_a: assert property ($fell(sleep_mode) && cfg_q.kind == 0
    |-> ##[1:2] cfg_q.bw_hz == 1200) else $error("wake not at full width");
  read_c: cover property (req.rd ##1 rd_valid_q);
  range_bad_c: cover property (cfg_q.range_bad);
  wake_c: cover property ($fell(sleep_mode));
endmodule

bind nvmcfg_top nvmcfg_asserts u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .req(req), .sleep_mode(sleep_mode), .rd_data_q(rd_data_q),
  .rd_valid_q(rd_valid_q), .cfg_q(cfg_q));

//--- nvmcfg_cfg.svh
`ifndef NVMCFG_CFG_SVH
`define NVMCFG_CFG_SVH
// Summary of operation
// - Store triggers rejected until unlock bit set
// - Image writes discarded while unlock bit clear
// - Write to 40h-5Bh starts store programming
// - Even address programs word, odd ignored
// - Trigger payload byte is disregarded
// - Image byte 20h below feeds store byte
// - Store bytes 5Ch-5Fh never host programmed
// - Images of protected bytes refuse writes
// - Programming 40h-5Bh sets written marker
// - Image registers readable without unlocking
// - Factory defaults for bandwidth, range, thresholds
// - Range code selects full scale, 111 invalid
// - Output invalid for 1/(2*bandwidth) after range change
// - Bandwidth code selects filter, 1010+ invalid
// - After wake, maximum bandwidth until filter filled
// - Reads of 40h-5Fh return images 20h-3Fh
// - Reload images on reset, soft reset, reload bit
// - Programmed store bytes reloaded into images

////////////////////////////////////////////////////////////////////////////
`define NVMCFG_ID_ADDR 7'h00
`define NVMCFG_CTRL_ADDR 7'h0d
`define NVMCFG_STAT_ADDR 7'h0e
`define NVMCFG_SRST_ADDR 7'h10
`define NVMCFG_SRST_CMD 8'ha5
`define NVMCFG_UNLOCK_BIT 4
`define NVMCFG_RELOAD_BIT 5
`define NVMCFG_IMG_LO 7'h20
`define NVMCFG_IMG_HI 7'h3f
`define NVMCFG_IMG_PROT_LO 7'h3c
`define NVMCFG_NVM_LO 7'h40
`define NVMCFG_NVM_HI 7'h5f
`define NVMCFG_NVM_PROT_LO 7'h5c

////////////////////////////////////////////////////////////////////////////
`define NVMCFG_MARK_IDX 5'h1f
`define NVMCFG_MARK_BIT 0
`define NVMCFG_BW_IDX 5'h10
`define NVMCFG_RANGE_IDX 5'h15
`define NVMCFG_UTH_IDX 5'h0a
`define NVMCFG_LTH_IDX 5'h09
`define NVMCFG_BW_RST 4'h4
`define NVMCFG_RANGE_RST 3'h2
`define NVMCFG_MODE_RST 2'h0
`define NVMCFG_UTH_RST 8'h50
`define NVMCFG_LTH_RST 8'h17
`define NVMCFG_WAKE_BW 4'h7

////////////////////////////////////////////////////////////////////////////
`define NVMCFG_CLK_HZ 250000000
`define NVMCFG_PROG_CYC 16
`define NVMCFG_SETTLE_REF_HZ 10
`endif

//--- nvmcfg_host.sv
`include "nvmcfg_cfg.svh"

module nvmcfg_host #(
  parameter int GAP_CYC = 2500000
) (
  input wire logic core_clk,
  input wire logic [7:0] rd_data_q,
  input wire logic rd_valid_q,
  output nvmcfg_pkg::nvmcfg_req_type req
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req = '0;
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req <= {1'b1, 1'b0, a, d};
    @(negedge core_clk);
    req <= '0;
  endtask
  // Bounded wait: a missing answer leaves x, which no compare accepts
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    d = 8'hxx;
    @(negedge core_clk);
    req <= {1'b0, 1'b1, a, 8'h00};
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      req <= '0;
      if (rd_valid_q === 1'b1) begin
        d = rd_data_q;
        break;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Gap shortened by parameter; never triggered asleep or mid reload
  task automatic trig(input logic [6:0] a);
    repeat (GAP_CYC) @(negedge core_clk);
    wr(a, 8'h00);
  endtask
  task automatic srst();
    wr(`NVMCFG_SRST_ADDR, `NVMCFG_SRST_CMD);
  endtask
  // 10 us apart; no interrupt source here to mask around it
  task automatic band_wr(input logic [7:0] d);
    repeat (2500) @(negedge core_clk);
    wr(7'h30, d);
  endtask
endmodule

//--- nvmcfg_pkg.sv
package nvmcfg_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } nvmcfg_req_type;

  typedef enum {
    NVMCFG_IDLE,
    NVMCFG_RELOAD,
    NVMCFG_PROG
  } nvmcfg_state_type;

  typedef enum logic [1:0] {
    NVMCFG_LOWPASS,
    NVMCFG_HIGHPASS,
    NVMCFG_BANDPASS,
    NVMCFG_BADCODE
  } nvmcfg_filt_type;

  typedef struct packed {
    nvmcfg_filt_type kind;
    logic [10:0] bw_hz;
    logic [14:0] full_scale_mg;
    logic range_bad;
    logic data_valid;
  } nvmcfg_cfg_out_type;
endpackage

//--- nvmcfg_tb.sv
`include "nvmcfg_cfg.svh"

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rst_n, sleep_mode, adc_sample, rd_valid_q;
  logic [7:0] rd_data_q, v;
  nvmcfg_pkg::nvmcfg_req_type req;
  nvmcfg_pkg::nvmcfg_cfg_out_type cfg_q;
  int fails, cmp_count;
  nvmcfg_host #(.GAP_CYC(50)) host (.core_clk(core_clk),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .req(req));
  nvmcfg_top #(.SETTLE_REF_CYC(100)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .req(req), .sleep_mode(sleep_mode),
    .adc_sample(adc_sample), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .cfg_q(cfg_q));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    host.rd(a, v);
    chk({8'h00, v}, {8'h00, e});
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 100; i++) begin
      host.rd(`NVMCFG_STAT_ADDR, v);
      if (v[1:0] === 2'b00)
        return;
    end
    fails++;
    report_and_stop();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    rdc(`NVMCFG_ID_ADDR, 8'h5a);
    rdc(7'h30, 8'h40);
    rdc(7'h35, 8'h04);
    rdc(7'h2a, 8'h50);
    rdc(7'h29, 8'h17);
    rdc(7'h50, 8'h40);
    rdc(7'h3f, 8'h00);
    chk({1'b0, cfg_q.full_scale_mg}, 16'h07d0);
    chk({5'h00, cfg_q.bw_hz}, 16'h0096);
  endtask
  task automatic t_locked();
    host.wr(7'h30, 8'h70);
    rdc(7'h30, 8'h40);
    host.trig(7'h50);
    rdc(`NVMCFG_STAT_ADDR, 8'h00);
  endtask
  task automatic t_prog();
    host.wr(`NVMCFG_CTRL_ADDR, 8'h10);
    host.wr(7'h30, 8'h70);
    host.wr(7'h31, 8'ha5);
    host.wr(7'h32, 8'h33);
    host.wr(7'h3c, 8'hff);
    rdc(7'h3c, 8'h00);
    rdc(7'h31, 8'ha5);
    host.trig(7'h51);
    rdc(`NVMCFG_STAT_ADDR, 8'h00);
    host.trig(7'h5c);
    rdc(`NVMCFG_STAT_ADDR, 8'h00);
    host.trig(7'h50);
    host.wr(7'h52, 8'h00);
    rdc(`NVMCFG_STAT_ADDR, 8'h01);
    wait_idle();
    rdc(7'h3f, 8'h01);
    host.wr(7'h30, 8'h00);
    host.srst();
    wait_idle();
    rdc(7'h30, 8'h70);
    rdc(7'h31, 8'ha5);
    rdc(7'h32, 8'h00);
    rdc(7'h50, 8'h70);
  endtask
  task automatic t_band();
    logic [15:0] hz [11] = '{16'h000a, 16'h0014, 16'h0028, 16'h004b,
      16'h0096, 16'h012c, 16'h0258, 16'h04b0, 16'h0001, 16'h012c, 16'h04b0};
    host.wr(`NVMCFG_CTRL_ADDR, 8'h10);
    for (int c = 0; c < 11; c++) begin
      host.band_wr({c[3:0], 4'h0});
      repeat (3) @(negedge core_clk);
      chk({5'h00, cfg_q.bw_hz}, hz[c]);
      chk({14'h0000, cfg_q.kind}, (c < 8) ? 16'h0000 : 16'(c - 7));
    end
    host.band_wr(8'h00);
  endtask
  task automatic t_range();
    logic [15:0] fs [7] = '{16'h03e8, 16'h05dc, 16'h07d0, 16'h0bb8,
      16'h0fa0, 16'h1f40, 16'h3e80};
    for (int c = 0; c < 7; c++) begin
      host.wr(7'h35, {4'h0, c[2:0], 1'b0});
      repeat (3) @(negedge core_clk);
      chk({1'b0, cfg_q.full_scale_mg}, fs[c]);
    end
    host.wr(7'h35, 8'h0e);
    repeat (3) @(negedge core_clk);
    chk({15'h0000, cfg_q.range_bad}, 16'h0001);
    chk({1'b0, cfg_q.full_scale_mg}, 16'h0000);
    // At 10 Hz the settle wait is 100 cycles with the shortened reference
    host.wr(7'h35, 8'h04);
    repeat (3) @(negedge core_clk);
    chk({15'h0000, cfg_q.data_valid}, 16'h0000);
    repeat (90) @(negedge core_clk);
    chk({15'h0000, cfg_q.data_valid}, 16'h0000);
    repeat (60) @(negedge core_clk);
    chk({15'h0000, cfg_q.data_valid}, 16'h0001);
  endtask
  task automatic t_wake();
    host.band_wr(8'h60);
    @(negedge core_clk);
    sleep_mode = 1'b1;
    repeat (5) @(negedge core_clk);
    sleep_mode = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({5'h00, cfg_q.bw_hz}, 16'h04b0);
    // 600 Hz needs six samples: one short must still be wide
    repeat (5) begin
      @(negedge core_clk);
      adc_sample = 1'b1;
      @(negedge core_clk);
      adc_sample = 1'b0;
    end
    repeat (3) @(negedge core_clk);
    chk({5'h00, cfg_q.bw_hz}, 16'h04b0);
    @(negedge core_clk);
    adc_sample = 1'b1;
    @(negedge core_clk);
    adc_sample = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({5'h00, cfg_q.bw_hz}, 16'h0258);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    rst_n = 1'b0;
    sleep_mode = 1'b0;
    adc_sample = 1'b0;
    fails = 0;
    cmp_count = 0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    wait_idle();
    t_defaults();
    t_locked();
    t_prog();
    t_band();
    t_range();
    t_wake();
    report_and_stop();
  end
endmodule

//--- nvmcfg_top.sv
`include "nvmcfg_cfg.svh"

module nvmcfg_top #(
  parameter logic [7:0] DEVICE_ID = 8'h5a, // Arbitrary value
  parameter int CLK_HZ = `NVMCFG_CLK_HZ,
  parameter int PROG_CYC = `NVMCFG_PROG_CYC,
  parameter int SETTLE_REF_CYC = CLK_HZ / (2 * `NVMCFG_SETTLE_REF_HZ)
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire nvmcfg_pkg::nvmcfg_req_type req,
  input wire logic sleep_mode,
  input wire logic adc_sample,
  output logic [7:0] rd_data_q,
  output logic rd_valid_q,
  output nvmcfg_pkg::nvmcfg_cfg_out_type cfg_q
);

  ////////////////////////////////////////////////////////////////////////////
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] factory_byte(input logic [4:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      `NVMCFG_BW_IDX: b = {`NVMCFG_BW_RST, 2'h0, `NVMCFG_MODE_RST};
      `NVMCFG_RANGE_IDX: b = {4'h0, `NVMCFG_RANGE_RST, 1'b0};
      `NVMCFG_UTH_IDX: b = `NVMCFG_UTH_RST;
      `NVMCFG_LTH_IDX: b = `NVMCFG_LTH_RST;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  function automatic logic [10:0] bw_hz_of(input logic [3:0] code);
    logic [10:0] hz;
    hz = 11'd1200;
    case (code)
      4'h0: hz = 11'd10;
      4'h1: hz = 11'd20;
      4'h2: hz = 11'd40;
      4'h3: hz = 11'd75;
      4'h4: hz = 11'd150;
      4'h5: hz = 11'd300;
      4'h6: hz = 11'd600;
      4'h8: hz = 11'd1;
      4'h9: hz = 11'd300;
      default: hz = 11'd1200;
    endcase
    return hz;
  endfunction

  // Converter samples needed to fill the filter after wake
  function automatic logic [7:0] fill_samples(input logic [3:0] code);
    logic [7:0] n;
    n = 8'hfd;
    case (code)
      4'h0: n = 8'hfd;
      4'h1: n = 8'h7f;
      4'h2: n = 8'h40;
      4'h3: n = 8'h23;
      4'h4: n = 8'h12;
      4'h5: n = 8'h09;
      4'h6: n = 8'h06;
      4'h7: n = 8'h00;
      default: n = 8'hfd;
    endcase
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] img_q [32];
  logic [7:0] nvm_q [32];
  logic unlock_q;
  nvmcfg_pkg::nvmcfg_state_type state_q;
  logic [4:0] idx_q;
  logic [$clog2(PROG_CYC+1)-1:0] prog_cnt_q;

  logic in_img;
  logic in_nvm;
  logic img_wr_ok;
  logic trig_ok;
  logic srst_cmd;
  logic reload_cmd;
  logic prog_done;

  assign in_img = req.addr >= `NVMCFG_IMG_LO && req.addr <= `NVMCFG_IMG_HI;
  assign in_nvm = req.addr >= `NVMCFG_NVM_LO && req.addr <= `NVMCFG_NVM_HI;
  // Protected shadows stay locked even with the unlock bit set
  assign img_wr_ok = req.wr && in_img && unlock_q
    && req.addr < `NVMCFG_IMG_PROT_LO;
  // Payload byte of a trigger is never looked at
  assign trig_ok = req.wr && in_nvm && unlock_q && !req.addr[0]
    && req.addr < `NVMCFG_NVM_PROT_LO
    && state_q == nvmcfg_pkg::NVMCFG_IDLE;
  assign srst_cmd = req.wr && req.addr == `NVMCFG_SRST_ADDR
    && req.wdata == `NVMCFG_SRST_CMD;
  assign reload_cmd = req.wr && req.addr == `NVMCFG_CTRL_ADDR
    && req.wdata[`NVMCFG_RELOAD_BIT];
  // Soft reset on the last cycle still drops the word
  assign prog_done = state_q == nvmcfg_pkg::NVMCFG_PROG
    && !srst_cmd
    && prog_cnt_q == ($clog2(PROG_CYC+1))'(PROG_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      unlock_q <= 1'b0;
    end else if (srst_cmd) begin
      unlock_q <= 1'b0;
    end else if (req.wr && req.addr == `NVMCFG_CTRL_ADDR) begin
      unlock_q <= req.wdata[`NVMCFG_UNLOCK_BIT];
    end
  end

  // Soft reset wins from any state; a word still in flight is dropped
  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= nvmcfg_pkg::NVMCFG_RELOAD;
      idx_q <= 5'h00;
      prog_cnt_q <= '0;
    end else begin
      case (state_q)
        nvmcfg_pkg::NVMCFG_IDLE: begin
          prog_cnt_q <= '0;
          if (srst_cmd || reload_cmd) begin
            state_q <= nvmcfg_pkg::NVMCFG_RELOAD;
            idx_q <= 5'h00;
          end else if (trig_ok) begin
            state_q <= nvmcfg_pkg::NVMCFG_PROG;
            idx_q <= req.addr[4:0];
          end
        end
        nvmcfg_pkg::NVMCFG_RELOAD: begin
          if (srst_cmd) begin
            idx_q <= 5'h00;
          end else begin
            idx_q <= idx_q + 5'h01;
            if (idx_q == 5'h1f) begin
              state_q <= nvmcfg_pkg::NVMCFG_IDLE;
            end
          end
        end
        nvmcfg_pkg::NVMCFG_PROG: begin
          prog_cnt_q <= prog_cnt_q + 1'b1;
          if (srst_cmd) begin
            state_q <= nvmcfg_pkg::NVMCFG_RELOAD;
            idx_q <= 5'h00;
          end else if (prog_done) begin
            state_q <= nvmcfg_pkg::NVMCFG_IDLE;
          end
        end
        default: state_q <= nvmcfg_pkg::NVMCFG_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Store content survives soft reset; only power-on restores defaults
  for (genvar i = 0; i < 32; i++) begin : g_byte
    logic word_hit;
    assign word_hit = prog_done && (idx_q == 5'(i) || idx_q + 5'h01 == 5'(i));

    always_ff @(posedge core_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
        nvm_q[i] <= factory_byte(5'(i));
      end else if (word_hit) begin
        nvm_q[i] <= img_q[i];
      end else if (prog_done && 5'(i) == `NVMCFG_MARK_IDX) begin
        nvm_q[i][`NVMCFG_MARK_BIT] <= 1'b1;
      end
    end

    always_ff @(posedge core_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
        img_q[i] <= 8'h00;
      end else if (state_q == nvmcfg_pkg::NVMCFG_RELOAD
          && idx_q == 5'(i)) begin
        img_q[i] <= nvm_q[i];
      end else if (prog_done && 5'(i) == `NVMCFG_MARK_IDX) begin
        img_q[i][`NVMCFG_MARK_BIT] <= 1'b1;
      end else if (img_wr_ok && req.addr[4:0] == 5'(i)) begin
        img_q[i] <= req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= req.rd;
      if (req.rd) begin
        if (req.addr == `NVMCFG_ID_ADDR) begin
          rd_data_q <= DEVICE_ID;
        end else if (req.addr == `NVMCFG_CTRL_ADDR) begin
          rd_data_q <= 8'(unlock_q) << `NVMCFG_UNLOCK_BIT;
        end else if (req.addr == `NVMCFG_STAT_ADDR) begin
          rd_data_q <= {6'h00, state_q == nvmcfg_pkg::NVMCFG_RELOAD,
            state_q == nvmcfg_pkg::NVMCFG_PROG};
        end else if (in_img || in_nvm) begin
          rd_data_q <= img_q[req.addr[4:0]];
        end else begin
          rd_data_q <= 8'h00;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] bw_code;
  logic [2:0] range_code;
  logic [3:0] eff_bw;
  logic sleep_prev_q;
  logic wake_busy_q;
  logic [7:0] fill_left_q;

  assign bw_code = img_q[`NVMCFG_BW_IDX][7:4];
  assign range_code = img_q[`NVMCFG_RANGE_IDX][3:1];
  assign eff_bw = wake_busy_q ? `NVMCFG_WAKE_BW : bw_code;

  // Wide filter after wake until enough samples have filled it
  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sleep_prev_q <= 1'b0;
      wake_busy_q <= 1'b0;
      fill_left_q <= 8'h00;
    end else begin
      sleep_prev_q <= sleep_mode;
      if (sleep_prev_q && !sleep_mode) begin
        fill_left_q <= fill_samples(bw_code);
        wake_busy_q <= fill_samples(bw_code) != 8'h00;
      end else if (wake_busy_q && adc_sample) begin
        fill_left_q <= fill_left_q - 8'h01;
        if (fill_left_q == 8'h01) begin
          wake_busy_q <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] range_prev_q;
  logic [31:0] settle_q;

  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cfg_q <= '0;
      range_prev_q <= 3'h0;
      settle_q <= 32'h0;
    end else begin
      range_prev_q <= range_code;
      cfg_q.bw_hz <= bw_hz_of(eff_bw);
      case (eff_bw)
        4'h8: cfg_q.kind <= nvmcfg_pkg::NVMCFG_HIGHPASS;
        4'h9: cfg_q.kind <= nvmcfg_pkg::NVMCFG_BANDPASS;
        default: begin
          cfg_q.kind <= eff_bw[3] ? nvmcfg_pkg::NVMCFG_BADCODE
            : nvmcfg_pkg::NVMCFG_LOWPASS;
        end
      endcase
      case (range_code)
        3'h0: cfg_q.full_scale_mg <= 15'd1000;
        3'h1: cfg_q.full_scale_mg <= 15'd1500;
        3'h2: cfg_q.full_scale_mg <= 15'd2000;
        3'h3: cfg_q.full_scale_mg <= 15'd3000;
        3'h4: cfg_q.full_scale_mg <= 15'd4000;
        3'h5: cfg_q.full_scale_mg <= 15'd8000;
        3'h6: cfg_q.full_scale_mg <= 15'd16000;
        default: cfg_q.full_scale_mg <= 15'd0;
      endcase
      cfg_q.range_bad <= range_code == 3'h7;
      // Reference wait is for 10 Hz; others scale by 10/bw
      if (range_code != range_prev_q) begin
        settle_q <= 32'((SETTLE_REF_CYC * `NVMCFG_SETTLE_REF_HZ)
          / int'(bw_hz_of(eff_bw)));
        cfg_q.data_valid <= 1'b0;
      end else if (settle_q != 32'h0) begin
        settle_q <= settle_q - 32'h1;
        cfg_q.data_valid <= 1'b0;
      end else begin
        cfg_q.data_valid <= range_code != 3'h7;
      end
    end
  end

endmodule
